//--- hdl/mfp_pkg.sv
// Package of constants and types for the multi-function pin configuration block
//----------------------------------------------------------------------------
// Operation
// - Pin A function field picks GPIO, driver enable, reset out, power good, sleep, wake.
// - Pin B function field picks GPIO, I2C clock, SPI select, watchdog trigger, sleep, wake.
// - Input deglitch bit 0 only synchronises; 1 adds an 8 us filter.
// - Pull enable bit 0 disconnects the pull resistor, 1 connects it.
// - Pull select picks down at 0, up at 1, only while pull enabled.
// - Output type bit picks push-pull at 0, open-drain at 1.
// - Direction bit 0 makes a GPIO pin an input, 1 an output; pin A driver enable, reset out and power good always drive.
// - Pin A register at 0x31 resets to 0x2A.
// - Pin B register at 0x32 resets to 0x0A.
// - Both registers fully readable and writable with the fixed field layout.
//----------------------------------------------------------------------------
package mfp_pkg;

    localparam int unsigned CLK_FREQ_HZ = 40000000;
    localparam int unsigned FILTER_TIME_NS = 8000;
    localparam int unsigned FILTER_CYCLES = (FILTER_TIME_NS * (CLK_FREQ_HZ / 1000000)) / 1000;

    localparam logic [7:0] PIN_A_CONFIG_OFFSET = 8'h31;
    localparam logic [7:0] PIN_B_CONFIG_OFFSET = 8'h32;
    localparam logic [7:0] PIN_A_CONFIG_RESET = 8'h2A;
    localparam logic [7:0] PIN_B_CONFIG_RESET = 8'h0A;

    localparam int unsigned FUNC_MSB = 7;
    localparam int unsigned FUNC_LSB = 5;
    localparam int unsigned FILTER_BIT = 4;
    localparam int unsigned PULL_ON_BIT = 3;
    localparam int unsigned PULL_UP_BIT = 2;
    localparam int unsigned OPEN_DRAIN_BIT = 1;
    localparam int unsigned DIRECTION_BIT = 0;

    // Function codes shared by both pins
    localparam logic [2:0] FN_GPIO = 3'h0;
    localparam logic [2:0] FN_ALT1 = 3'h1;
    localparam logic [2:0] FN_ALT2 = 3'h2;
    localparam logic [2:0] FN_ALT3 = 3'h3;
    localparam logic [2:0] FN_SLEEP_ONE = 3'h4;
    localparam logic [2:0] FN_SLEEP_TWO = 3'h5;
    localparam logic [2:0] FN_WAKE_ONE = 3'h6;
    localparam logic [2:0] FN_WAKE_TWO = 3'h7;

    // Configuration fields of one pin
    typedef struct packed {
        logic [2:0] function_select;
        logic filter_on;
        logic pull_on;
        logic pull_up_choice;
        logic open_drain;
        logic direction;
    } mfp_config_t;

    // Pad controls for one pin
    typedef struct packed {
        logic pull_up_on;
        logic pull_down_on;
        logic pad_out;
        logic pad_oe_n;
    } mfp_pad_t;

endpackage : mfp_pkg

//--- hdl/mfp_filter.sv
// Input synchroniser with optional stable-time deglitch filter
`timescale 1ns/1ps
`default_nettype none
module mfp_filter #(
    parameter int unsigned STABLE_CYCLES = mfp_pkg::FILTER_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic pin_in,
    input wire logic filter_on_in,
    output logic level_out
);
    localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(STABLE_CYCLES - 1);

    logic sync1_q;
    logic sync2_q;
    logic [CW-1:0] count_q;
    logic level_q;
    wire logic differs = sync2_q != level_q;
    wire logic expired = count_q >= LAST;

    //----------------------------------------------------------------------
    // Two-stage synchroniser, then filter
    //----------------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            count_q <= '0;
            level_q <= 1'b0;
        end else if (clk_en_in) begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            if (!filter_on_in) begin
                level_q <= sync2_q;
                count_q <= '0;
            end else if (!differs) begin
                count_q <= '0;
            end else if (expired) begin
                level_q <= sync2_q;
                count_q <= '0;
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    assign level_out = level_q;
endmodule : mfp_filter
`default_nettype wire

//--- hdl/mfp_pad_ctrl.sv
// Pad control for one pin: pulls, drive type, direction
`timescale 1ns/1ps
`default_nettype none
module mfp_pad_ctrl (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire mfp_pkg::mfp_config_t cfg_in,
    input wire logic drive_in,
    input wire logic is_output_in,
    output mfp_pkg::mfp_pad_t pad_out
);
    wire logic drive_low = !drive_in;
    wire logic enable_drive = is_output_in && (!cfg_in.open_drain || drive_low);
    mfp_pkg::mfp_pad_t pad_d;

    // Pull and drive decode
    always_comb begin
        pad_d.pull_up_on = cfg_in.pull_on && cfg_in.pull_up_choice;
        pad_d.pull_down_on = cfg_in.pull_on && !cfg_in.pull_up_choice;
        pad_d.pad_out = drive_in;
        pad_d.pad_oe_n = !enable_drive;
    end

    // Registered pad controls
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            pad_out <= '{pull_up_on: 1'b0, pull_down_on: 1'b0, pad_out: 1'b0, pad_oe_n: 1'b1};
        end else if (clk_en_in) begin
            pad_out <= pad_d;
        end
    end
endmodule : mfp_pad_ctrl
`default_nettype wire

//--- hdl/mfp_top.sv
// Top of the two multi-function pin configuration block
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module mfp_top #(
    parameter int unsigned STABLE_CYCLES = mfp_pkg::FILTER_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    // Pads
    input wire logic pin_a_in,
    input wire logic pin_b_in,
    output mfp_pkg::mfp_pad_t pin_a_pad_out,
    output mfp_pkg::mfp_pad_t pin_b_pad_out,
    // Core-side signals driven out through the pins
    input wire logic pin_a_gpio_out_in,
    input wire logic pin_b_gpio_out_in,
    input wire logic external_driver_enable_in,
    input wire logic processor_reset_out_in,
    input wire logic power_good_out_in,
    input wire logic secondary_i2c_clock_drive_in,
    // Pin levels delivered to the core
    output logic pin_a_gpio_level_out,
    output logic pin_b_gpio_level_out,
    output logic secondary_i2c_clock_out,
    output logic spi_chip_select_n_out,
    output logic watchdog_trigger_out,
    output logic sleep_request_one_out,
    output logic sleep_request_two_out,
    output logic wake_input_one_out,
    output logic wake_input_two_out
);
    //------------------------------------------------------------------------
    // Configuration registers
    //------------------------------------------------------------------------
    mfp_pkg::mfp_config_t pin_a_config_q;
    mfp_pkg::mfp_config_t pin_b_config_q;
    logic [7:0] rdata_q;

    wire logic hit_a = reg_addr_in == mfp_pkg::PIN_A_CONFIG_OFFSET;
    wire logic hit_b = reg_addr_in == mfp_pkg::PIN_B_CONFIG_OFFSET;
    wire logic [7:0] rdata_d = hit_a ? pin_a_config_q : (hit_b ? pin_b_config_q : 8'h00);

    // Register writes, full byte on a hit
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            pin_a_config_q <= mfp_pkg::PIN_A_CONFIG_RESET;
            pin_b_config_q <= mfp_pkg::PIN_B_CONFIG_RESET;
        end else if (clk_en_in && reg_write_in) begin
            if (hit_a) begin
                pin_a_config_q <= reg_wdata_in;
            end
            if (hit_b) begin
                pin_b_config_q <= reg_wdata_in;
            end
        end
    end

    // Read data in the cycle after the strobe only
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            rdata_q <= 8'h00;
        end else if (clk_en_in) begin
            rdata_q <= reg_read_in ? rdata_d : 8'h00;
        end
    end
    assign reg_rdata_out = rdata_q;

    //------------------------------------------------------------------------
    // Input paths
    //------------------------------------------------------------------------
    logic level_a;
    logic level_b;

    mfp_filter #(.STABLE_CYCLES(STABLE_CYCLES)) u_filter_a (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .clk_en_in(clk_en_in),
        .pin_in(pin_a_in),
        .filter_on_in(pin_a_config_q.filter_on),
        .level_out(level_a)
    );

    mfp_filter #(.STABLE_CYCLES(STABLE_CYCLES)) u_filter_b (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .clk_en_in(clk_en_in),
        .pin_in(pin_b_in),
        .filter_on_in(pin_b_config_q.filter_on),
        .level_out(level_b)
    );

    //------------------------------------------------------------------------
    // Function routing
    //------------------------------------------------------------------------
    wire logic [2:0] fn_a = pin_a_config_q.function_select;
    wire logic [2:0] fn_b = pin_b_config_q.function_select;
    wire logic in_a = !pin_a_config_q.direction;
    wire logic in_b = !pin_b_config_q.direction;

    // Pin A drive source: GPIO, driver enable, reset out, power good
    logic drive_a;
    logic out_a;
    always_comb begin
        drive_a = 1'b0;
        out_a = 1'b0;
        case (fn_a)
            mfp_pkg::FN_GPIO: begin
                drive_a = pin_a_gpio_out_in;
                out_a = pin_a_config_q.direction;
            end
            mfp_pkg::FN_ALT1: begin
                drive_a = external_driver_enable_in;
                out_a = 1'b1;
            end
            mfp_pkg::FN_ALT2: begin
                drive_a = processor_reset_out_in;
                out_a = 1'b1;
            end
            mfp_pkg::FN_ALT3: begin
                drive_a = power_good_out_in;
                out_a = 1'b1;
            end
            default: begin
                drive_a = 1'b0;
                out_a = 1'b0;
            end
        endcase
    end

    // Pin B drive source: GPIO or secondary I2C clock
    logic drive_b;
    logic out_b;
    always_comb begin
        drive_b = 1'b0;
        out_b = 1'b0;
        case (fn_b)
            mfp_pkg::FN_GPIO: begin
                drive_b = pin_b_gpio_out_in;
                out_b = pin_b_config_q.direction;
            end
            mfp_pkg::FN_ALT1: begin
                drive_b = secondary_i2c_clock_drive_in;
                out_b = pin_b_config_q.direction;
            end
            default: begin
                drive_b = 1'b0;
                out_b = 1'b0;
            end
        endcase
    end

    mfp_pad_ctrl u_pad_a (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .clk_en_in(clk_en_in),
        .cfg_in(pin_a_config_q),
        .drive_in(drive_a),
        .is_output_in(out_a),
        .pad_out(pin_a_pad_out)
    );

    mfp_pad_ctrl u_pad_b (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .clk_en_in(clk_en_in),
        .cfg_in(pin_b_config_q),
        .drive_in(drive_b),
        .is_output_in(out_b),
        .pad_out(pin_b_pad_out)
    );

    // Input functions; idle levels when not routed
    wire logic slp1_d = (fn_a == mfp_pkg::FN_SLEEP_ONE && in_a) ? level_a
                      : ((fn_b == mfp_pkg::FN_SLEEP_ONE && in_b) ? level_b : 1'b1);
    wire logic slp2_d = (fn_a == mfp_pkg::FN_SLEEP_TWO && in_a) ? level_a
                      : ((fn_b == mfp_pkg::FN_SLEEP_TWO && in_b) ? level_b : 1'b1);
    wire logic wk1_d = ((fn_a == mfp_pkg::FN_WAKE_ONE && in_a) && level_a)
                     || ((fn_b == mfp_pkg::FN_WAKE_ONE && in_b) && level_b);
    wire logic wk2_d = ((fn_a == mfp_pkg::FN_WAKE_TWO && in_a) && level_a)
                     || ((fn_b == mfp_pkg::FN_WAKE_TWO && in_b) && level_b);
    wire logic scl_d = (fn_b == mfp_pkg::FN_ALT1) ? level_b : 1'b1;
    wire logic cs_d = (fn_b == mfp_pkg::FN_ALT2 && in_b) ? level_b : 1'b1;
    wire logic wdt_d = (fn_b == mfp_pkg::FN_ALT3 && in_b) && level_b;
    wire logic gpa_d = (fn_a == mfp_pkg::FN_GPIO) && level_a;
    wire logic gpb_d = (fn_b == mfp_pkg::FN_GPIO) && level_b;

    // Registered core-side outputs
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            sleep_request_one_out <= 1'b1;
            sleep_request_two_out <= 1'b1;
            wake_input_one_out <= 1'b0;
            wake_input_two_out <= 1'b0;
            secondary_i2c_clock_out <= 1'b1;
            spi_chip_select_n_out <= 1'b1;
            watchdog_trigger_out <= 1'b0;
            pin_a_gpio_level_out <= 1'b0;
            pin_b_gpio_level_out <= 1'b0;
        end else if (clk_en_in) begin
            sleep_request_one_out <= slp1_d;
            sleep_request_two_out <= slp2_d;
            wake_input_one_out <= wk1_d;
            wake_input_two_out <= wk2_d;
            secondary_i2c_clock_out <= scl_d;
            spi_chip_select_n_out <= cs_d;
            watchdog_trigger_out <= wdt_d;
            pin_a_gpio_level_out <= gpa_d;
            pin_b_gpio_level_out <= gpb_d;
        end
    end
endmodule : mfp_top
`default_nettype wire

//--- verification/mfp_board.sv
// Board model that drives one pin
`timescale 1ns/1ps
`default_nettype none
module mfp_board (
    input wire logic core_clk_in,
    input wire mfp_pkg::mfp_pad_t pad_in,
    input wire logic ext_on_in,
    input wire logic ext_level_in,
    output logic pin_out
);
    logic float_q = 1'b0;
    // A pin nobody holds wanders each cycle
    always_ff @(posedge core_clk_in) float_q <= !float_q;
    // Pad drive wins, then board drive, then pull
    always_comb begin
        if (!pad_in.pad_oe_n) pin_out = pad_in.pad_out;
        else if (ext_on_in) pin_out = ext_level_in;
        else if (pad_in.pull_up_on) pin_out = 1'b1;
        else if (pad_in.pull_down_on) pin_out = 1'b0;
        else pin_out = float_q;
    end
endmodule : mfp_board
`default_nettype wire

//--- verification/mfp_chk.sv
// Checker for the pin configuration block
`timescale 1ns/1ps
`default_nettype none
module mfp_chk (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    input wire mfp_pkg::mfp_pad_t pin_a_pad_out,
    input wire mfp_pkg::mfp_pad_t pin_b_pad_out,
    input wire logic processor_reset_out_in,
    input wire logic watchdog_trigger_out
);
    logic [7:0] a_q;
    logic [7:0] b_q;
    logic [7:0] pa_q;
    logic [7:0] pb_q;
    logic live_q;
    // Shadow configuration and its value one cycle back
    always_ff @(posedge core_clk_in) begin
        live_q <= !reset_in;
        pa_q <= a_q;
        pb_q <= b_q;
        if (reset_in) begin
            a_q <= mfp_pkg::PIN_A_CONFIG_RESET;
            b_q <= mfp_pkg::PIN_B_CONFIG_RESET;
        end else if (clk_en_in && reg_write_in) begin
            if (reg_addr_in == 8'h31) a_q <= reg_wdata_in;
            if (reg_addr_in == 8'h32) b_q <= reg_wdata_in;
        end
    end
    // ---
    // Properties
    // ---
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    AST_RD_IDLE: assert property (!$past(reg_read_in) |-> reg_rdata_out == 8'h00)
        else $error("read data not zero");
    AST_RD_A: assert property ($past(reg_read_in) && $past(reg_addr_in) == 8'h31 |-> reg_rdata_out == pa_q)
        else $error("pin A read wrong");
    AST_RD_B: assert property ($past(reg_read_in) && $past(reg_addr_in) == 8'h32 |-> reg_rdata_out == pb_q)
        else $error("pin B read wrong");
    AST_PULL_OFF: assert property (live_q && !pa_q[3] |->
        !pin_a_pad_out.pull_up_on && !pin_a_pad_out.pull_down_on)
        else $error("pull not off");
    AST_PULL_SEL: assert property (live_q && pb_q[3] |->
        pin_b_pad_out.pull_up_on == pb_q[2] && pin_b_pad_out.pull_down_on != pb_q[2])
        else $error("pull choice wrong");
    AST_OD: assert property (live_q && pa_q[1] |-> pin_a_pad_out.pad_oe_n || !pin_a_pad_out.pad_out)
        else $error("open drain drove high");
    AST_IN_B: assert property (live_q && !pb_q[0] && !pb_q[7] |-> pin_b_pad_out.pad_oe_n)
        else $error("input pin driven");
    AST_SRC_A: assert property (live_q && pa_q[7:5] == 3'h2 && !pa_q[1] |->
        !pin_a_pad_out.pad_oe_n && pin_a_pad_out.pad_out == $past(processor_reset_out_in))
        else $error("reset source not routed");
    AST_WDOG: assert property (pb_q[7:5] != 3'h3 && $past(pb_q[7:5]) != 3'h3 |-> !watchdog_trigger_out)
        else $error("watchdog trigger leaked");
    cover property (watchdog_trigger_out);
    cover property ($past(reg_read_in) && reg_rdata_out != 8'h00);
    cover property (live_q && !pin_a_pad_out.pad_oe_n);
endmodule : mfp_chk
bind mfp_top mfp_chk chk_u (.*);
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the pin configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk;
    logic rst;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_s;
    logic rd_s;
    logic [7:0] rdata;
    logic pin_a;
    logic pin_b;
    logic ext_on;
    logic ext_lvl;
    logic en;
    logic [5:0] src;
    logic [7:0] c;
    logic [8:0] e;
    logic [31:0] v;
    logic val;
    logic oe;
    wire [8:0] sense;
    mfp_pkg::mfp_pad_t pad_a;
    mfp_pkg::mfp_pad_t pad_b;
    int mismatches = 0;
    int total_checks = 0;
    int seed = 32'h916d0af1;
    int cfg_m [2];
    int i;
    int n;
    mfp_top #(.STABLE_CYCLES(4)) dut_u (
        .core_clk_in(clk), .reset_in(rst), .clk_en_in(en), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_rdata_out(rdata), .pin_a_in(pin_a), .pin_b_in(pin_b),
        .pin_a_pad_out(pad_a), .pin_b_pad_out(pad_b), .pin_a_gpio_out_in(src[3]), .pin_b_gpio_out_in(src[5]),
        .external_driver_enable_in(src[2]), .processor_reset_out_in(src[1]), .power_good_out_in(src[0]),
        .secondary_i2c_clock_drive_in(src[4]), .pin_a_gpio_level_out(sense[8]), .pin_b_gpio_level_out(sense[7]),
        .secondary_i2c_clock_out(sense[6]), .spi_chip_select_n_out(sense[5]), .watchdog_trigger_out(sense[4]),
        .sleep_request_one_out(sense[3]), .sleep_request_two_out(sense[2]), .wake_input_one_out(sense[1]),
        .wake_input_two_out(sense[0])
    );
    mfp_board board_a (.core_clk_in(clk), .pad_in(pad_a), .ext_on_in(ext_on), .ext_level_in(ext_lvl), .pin_out(pin_a));
    mfp_board board_b (.core_clk_in(clk), .pad_in(pad_b), .ext_on_in(ext_on), .ext_level_in(ext_lvl), .pin_out(pin_b));
    // Clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = !clk;
    end
    // Compare and count
    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Model update then register write
    task automatic set(input int p, input int d);
        if (p < 2) begin
            cfg_m[p] = d & 255;
        end
        @(posedge clk);
        addr <= 8'(8'h31 + p);
        wdata <= 8'(d);
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : set
    // Register read compared with expectation
    task automatic rd_chk(input logic [7:0] a, input int d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        chk("rdata", 9'(rdata), 9'(d));
    endtask : rd_chk
    // Verdict
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    // Hang guard
    initial begin
        #2000000;
        mismatches++;
        close_out();
    end
    // Main sequence
    initial begin
        rst <= 1'b1;
        en <= 1'b1;
        addr <= 8'h00;
        wdata <= 8'h00;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        ext_on <= 1'b0;
        ext_lvl <= 1'b0;
        src <= 6'h00;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_chk(8'h31, 8'h2A);
        rd_chk(8'h32, 8'h0A);
        set(2, 8'hFF);
        rd_chk(8'h33, 0);
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            set(i % 2, v);
            rd_chk(8'(8'h31 + i % 2), cfg_m[i % 2]);
        end
        // Clock enable low: a write in that cycle is not taken
        @(posedge clk);
        en <= 1'b0;
        addr <= 8'h32;
        wdata <= ~8'(cfg_m[1]);
        wr_s <= 1'b1;
        @(posedge clk);
        en <= 1'b1;
        wr_s <= 1'b0;
        rd_chk(8'h32, cfg_m[1]);
        // Reset in mid-run brings both registers back to their defaults
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        cfg_m[0] = mfp_pkg::PIN_A_CONFIG_RESET;
        cfg_m[1] = mfp_pkg::PIN_B_CONFIG_RESET;
        rd_chk(8'h31, cfg_m[0]);
        rd_chk(8'h32, cfg_m[1]);
        $display("test registers done");
        // Pin A drive for each drive function (GPIO, ALT1 to ALT3), type and direction
        for (i = 0; i < 16; i++) begin
            v = $random(seed);
            src <= v[13:8];
            set(0, {i[1:0], v[2:0], i[2], i[3]});
            repeat (3) @(posedge clk);
            @(negedge clk);
            c = 8'(cfg_m[0]);
            val = src[3 - c[6:5]];
            oe = !(c[0] || c[6:5] != 0) || (c[1] && val);
            chk("pad a", 9'({pad_a.pull_up_on, pad_a.pull_down_on,
                pad_a.pad_oe_n ? 1'b0 : pad_a.pad_out, pad_a.pad_oe_n}),
                9'({c[3] & c[2], c[3] & !c[2], oe ? 1'b0 : val, oe}));
        end
        $display("test pads done");
        // Every function code of both pins
        ext_on <= 1'b1;
        for (i = 0; i < 32; i++) begin
            set(1 - i / 16, 0);
            set(i / 16, (i / 2 % 8) * 32);
            ext_lvl <= i[0];
            repeat (8) @(posedge clk);
            @(negedge clk);
            e = 9'h06C;
            e[7 + i / 16] = i[0];
            if (i / 2 % 8 == 0) e[8 - i / 16] = i[0];
            else if (i >= 16 || i / 2 % 8 > 3) e[7 - i / 2 % 8] = i[0];
            chk("sense", sense, e);
        end
        $display("test functions done");
        // Short pulse dropped, long level passed late
        set(1, 8'h10);
        ext_lvl <= 1'b0;
        repeat (12) @(posedge clk);
        ext_lvl <= 1'b1;
        repeat (2) @(posedge clk);
        ext_lvl <= 1'b0;
        repeat (12) @(negedge clk);
        chk("pulse", 9'(sense[7]), 9'h000);
        for (i = 0; i < 2; i++) begin
            set(1, 16 - 16 * i);
            ext_lvl <= !i[0];
            n = 0;
            while (sense[7] !== !i[0] && n < 40) begin
                @(negedge clk);
                n++;
            end
            chk("level", 9'(sense[7]), 9'(!i[0]));
            chk("slow", 9'(n > 6), 9'(!i[0]));
            if (n == 40) close_out();
        end
        $display("test filter done");
        close_out();
    end
endmodule : testbench
`default_nettype wire
